// file: rtl/sogm_pkg.sv
/*
 package of the safety output gating monitor: timing counts, register map,
 diagnostics command codes, state enums and pin structs.
 assumes a 250 MHz system clock.
*/
package sogm_pkg;
   // timing
   localparam int CLK_NS = 4;
   localparam int STARTUP_NS = 1000;
   localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DIAG_BIT_NS = 8000;
   localparam int DIAG_BIT_CYC = DIAG_BIT_NS / CLK_NS;
   localparam logic [11:0] TMR_FULL = 12'(DIAG_BIT_CYC - 1);
   localparam logic [11:0] TMR_HALF = 12'(DIAG_BIT_CYC / 2 - 1);
   localparam logic [7:0] START_DONE = 8'(STARTUP_CYC);
   localparam int FAST_BIT = 21;
   localparam int SLOW_BIT = 24;
   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_TEACH = 8'h10;
   localparam logic [7:0] ADDR_NAME = 8'h14;
   localparam logic [7:0] ADDR_SERIAL = 8'h18;
   // interrupt bits
   localparam int IRQ_UNEQUAL = 0;
   localparam int IRQ_LOCK = 1;
   localparam int IRQ_ACT = 2;
   localparam int IRQ_DIAG = 3;
   // reset values; serial value is arbitrary
   localparam logic [15:0] TEACH_RESET = 16'h0020;
   localparam logic [15:0] SERIAL_NUM = 16'h1234;
   // diagnostics commands
   localparam logic [7:0] CMD_STATUS = 8'h01;
   localparam logic [7:0] CMD_SERIAL = 8'h02;
   localparam logic [7:0] CMD_TEACH = 8'h03;
   localparam logic [7:0] CMD_NAME = 8'h04;
   localparam logic [3:0] RX_LAST = 4'h7;
   localparam logic [4:0] TX_LAST = 5'h11;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {PL_NORMAL, PL_UNEQUAL, PL_LOCK} sogm_pl_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} sogm_rx_e;

   typedef struct packed {
      logic diag_input;
      logic safety_input_two;
      logic safety_input_one;
      logic actuator_detect;
   } sogm_pins_in_s;

   typedef struct packed {
      logic status_diag_output;
      logic safety_out_two;
      logic safety_out_one;
   } sogm_pins_out_s;

   typedef struct packed {
      logic input_yellow;
      logic device_red;
      logic device_green;
   } sogm_leds_s;
endpackage

// file: rtl/sogm_top.sv
/*
 safety output gating monitor: dual-channel output gating, input
 plausibility checking, diagnostics link and an axi4-lite register slave.
 assumes pins are asynchronous to clk_sys and the bus is on clk_sys.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
// Functional notes
// - with actuator present each output copies its own input channel
// - actuator absent forces both outputs low
// - mapping only applies once the device is ready (green)
// - one input falls while other high: unequal state, fast yellow, red
// - fallen input returns high: plausibility error, partial lock, yellow, red
// - rising edge accepted only after both inputs were low together
// - without diagnostics, status output shows actuator presence
// - diagnostic input enabled on module attach, ignored otherwise
// - with module attached, status output carries transmit data
// - diagnostics link rebuilt after every power-up
// - serial number and remaining teach-ins readable over the link
// - status word tells switching and open-circuit location
// - on request, return the taught actuator name
`timescale 1ns/1ps
module sogm_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pins
   input sogm_pkg::sogm_pins_in_s pins_in,
   output sogm_pkg::sogm_pins_out_s pins_out,
   output sogm_pkg::sogm_leds_s leds,
   output logic irq,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] prev;
      logic [7:0] start_cnt;
      logic ready;
      sogm_pkg::sogm_pl_e pl;
      logic fell_two;
      logic attached;
      sogm_pkg::sogm_rx_e rx;
      logic [11:0] rx_tmr;
      logic [3:0] rx_cnt;
      logic [7:0] rx_sh;
      logic tx_busy;
      logic [11:0] tx_tmr;
      logic [4:0] tx_cnt;
      logic [17:0] tx_sh;
      logic [24:0] blink;
      sogm_pkg::sogm_pins_out_s pout;
      sogm_pkg::sogm_leds_s leds;
      logic run;
      logic [3:0] irq_st;
      logic [3:0] irq_mask;
      logic [15:0] teach;
      logic [15:0] name;
      logic irq;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
   } sogm_state_s;

   sogm_state_s s;
   sogm_state_s next_s;

   // byte-lane merge, shared by every writable register
   function automatic logic [31:0] sogm_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // whole next-state computation
   always_comb begin
      logic act, i1, i2, dg, p1, p2, gate, cmd_done;
      logic [7:0] cmd;
      logic [15:0] word;
      logic [3:0] ev;
      logic [31:0] wr;
      next_s = s;
      act = s.sync2[0];
      i1 = s.sync2[1];
      i2 = s.sync2[2];
      dg = s.sync2[3];
      p1 = s.prev[1];
      p2 = s.prev[2];
      cmd_done = 1'b0;
      gate = 1'b0;
      ev = 4'h0;
      cmd = {dg, s.rx_sh[7:1]};
      word = 16'h0000;
      wr = 32'h0000_0000;
      // first stage feeds only the second stage
      next_s.sync1 = pins_in;
      next_s.sync2 = s.sync1;
      next_s.prev = s.sync2;
      // ready after the startup wait and while enabled
      if (s.start_cnt != sogm_pkg::START_DONE) begin
         next_s.start_cnt = s.start_cnt + 8'h01;
      end
      next_s.ready = s.run && (s.start_cnt == sogm_pkg::START_DONE);
      // plausibility of the two channels
      case (s.pl)
         sogm_pkg::PL_NORMAL: begin
            if (p1 && !i1 && i2) begin
               next_s.pl = sogm_pkg::PL_UNEQUAL;
               next_s.fell_two = 1'b0;
            end else if (p2 && !i2 && i1) begin
               next_s.pl = sogm_pkg::PL_UNEQUAL;
               next_s.fell_two = 1'b1;
            end
         end
         sogm_pkg::PL_UNEQUAL: begin
            if (!i1 && !i2) begin
               next_s.pl = sogm_pkg::PL_NORMAL;
            end else if (s.fell_two ? (!p2 && i2 && i1) : (!p1 && i1 && i2)) begin
               next_s.pl = sogm_pkg::PL_LOCK;
            end
         end
         sogm_pkg::PL_LOCK: begin
            if (!i1 && !i2) begin
               next_s.pl = sogm_pkg::PL_NORMAL;
            end
         end
         default: next_s.pl = sogm_pkg::PL_NORMAL;
      endcase
      // gating; the fallen channel stays low so a re-rise never leaks out
      gate = s.ready && act && (s.pl != sogm_pkg::PL_LOCK);
      next_s.pout.safety_out_one = gate && i1 && !(s.pl == sogm_pkg::PL_UNEQUAL && !s.fell_two);
      next_s.pout.safety_out_two = gate && i2 && !(s.pl == sogm_pkg::PL_UNEQUAL && s.fell_two);
      // attach on first falling edge of the idle-high diag line
      if (!s.attached && s.prev[3] && !dg) begin
         next_s.attached = 1'b1;
      end
      // status output: plain presence or serial transmit data
      if (!s.attached) begin
         next_s.pout.status_diag_output = act;
      end else begin
         next_s.pout.status_diag_output = s.tx_busy ? s.tx_sh[0] : 1'b1;
      end
      // command receiver, start bit sampled mid-bit, lsb first
      case (s.rx)
         sogm_pkg::RX_IDLE: begin
            if (s.attached && s.prev[3] && !dg) begin
               next_s.rx = sogm_pkg::RX_START;
               next_s.rx_tmr = sogm_pkg::TMR_HALF;
            end
         end
         sogm_pkg::RX_START: begin
            if (s.rx_tmr == 12'h000) begin
               next_s.rx = dg ? sogm_pkg::RX_IDLE : sogm_pkg::RX_DATA;
               next_s.rx_tmr = sogm_pkg::TMR_FULL;
               next_s.rx_cnt = 4'h0;
            end else begin
               next_s.rx_tmr = s.rx_tmr - 12'h001;
            end
         end
         sogm_pkg::RX_DATA: begin
            if (s.rx_tmr == 12'h000) begin
               next_s.rx_sh = cmd;
               next_s.rx_tmr = sogm_pkg::TMR_FULL;
               next_s.rx_cnt = s.rx_cnt + 4'h1;
               if (s.rx_cnt == sogm_pkg::RX_LAST) begin
                  next_s.rx = sogm_pkg::RX_IDLE;
                  cmd_done = 1'b1;
               end
            end else begin
               next_s.rx_tmr = s.rx_tmr - 12'h001;
            end
         end
         default: next_s.rx = sogm_pkg::RX_IDLE;
      endcase
      // answer selection; a command during a reply is dropped
      case (cmd)
         sogm_pkg::CMD_STATUS: word = {9'h000, s.pl == sogm_pkg::PL_LOCK, s.pl == sogm_pkg::PL_UNEQUAL,
                                       s.pout.safety_out_two, s.pout.safety_out_one, i2, i1, act};
         sogm_pkg::CMD_SERIAL: word = sogm_pkg::SERIAL_NUM;
         sogm_pkg::CMD_TEACH: word = s.teach;
         sogm_pkg::CMD_NAME: word = s.name;
         default: word = 16'h0000;
      endcase
      // transmitter: start low, 16 data bits lsb first, stop high
      if (s.tx_busy) begin
         if (s.tx_tmr == 12'h000) begin
            next_s.tx_sh = {1'b1, s.tx_sh[17:1]};
            next_s.tx_tmr = sogm_pkg::TMR_FULL;
            next_s.tx_cnt = s.tx_cnt + 5'h01;
            if (s.tx_cnt == sogm_pkg::TX_LAST) begin
               next_s.tx_busy = 1'b0;
            end
         end else begin
            next_s.tx_tmr = s.tx_tmr - 12'h001;
         end
      end else if (cmd_done) begin
         next_s.tx_busy = 1'b1;
         next_s.tx_sh = {1'b1, word, 1'b0};
         next_s.tx_tmr = sogm_pkg::TMR_FULL;
         next_s.tx_cnt = 5'h00;
      end
      // indicators
      next_s.blink = s.blink + 25'h000_0001;
      next_s.leds.device_green = s.ready && (s.pl == sogm_pkg::PL_NORMAL);
      next_s.leds.device_red = (s.pl != sogm_pkg::PL_NORMAL) && s.blink[sogm_pkg::SLOW_BIT];
      case (s.pl)
         sogm_pkg::PL_UNEQUAL: next_s.leds.input_yellow = s.blink[sogm_pkg::FAST_BIT];
         sogm_pkg::PL_LOCK: next_s.leds.input_yellow = s.blink[sogm_pkg::SLOW_BIT];
         default: next_s.leds.input_yellow = i1 && i2;
      endcase
      // sticky events; an event in the clearing read's cycle survives
      ev[sogm_pkg::IRQ_UNEQUAL] = (s.pl == sogm_pkg::PL_NORMAL) && (next_s.pl == sogm_pkg::PL_UNEQUAL);
      ev[sogm_pkg::IRQ_LOCK] = (s.pl != sogm_pkg::PL_LOCK) && (next_s.pl == sogm_pkg::PL_LOCK);
      ev[sogm_pkg::IRQ_ACT] = act != s.prev[0];
      ev[sogm_pkg::IRQ_DIAG] = cmd_done;
      next_s.irq_st = s.irq_st | ev;
      // read channel
      if (s.arready && s_axi_arvalid) begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = sogm_pkg::RESP_OKAY;
         case (s_axi_araddr)
            sogm_pkg::ADDR_CTRL: next_s.rdata = {31'h0000_0000, s.run};
            sogm_pkg::ADDR_STATUS: next_s.rdata = {21'h00_0000, s.attached, s.pl == sogm_pkg::PL_LOCK,
                                                  s.pl == sogm_pkg::PL_UNEQUAL, s.ready, s.pout, s.sync2};
            sogm_pkg::ADDR_IRQ_STAT: begin
               next_s.rdata = {28'h000_0000, s.irq_st};
               next_s.irq_st = ev;
            end
            sogm_pkg::ADDR_IRQ_MASK: next_s.rdata = {28'h000_0000, s.irq_mask};
            sogm_pkg::ADDR_TEACH: next_s.rdata = {16'h0000, s.teach};
            sogm_pkg::ADDR_NAME: next_s.rdata = {16'h0000, s.name};
            sogm_pkg::ADDR_SERIAL: next_s.rdata = {16'h0000, sogm_pkg::SERIAL_NUM};
            default: begin
               next_s.rdata = 32'h0000_0000;
               next_s.rresp = sogm_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
      // write channel: address and data in either order
      if (s.awready && s_axi_awvalid) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s.wready && s_axi_wvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = sogm_pkg::RESP_OKAY;
         case (s.awaddr)
            sogm_pkg::ADDR_CTRL: begin
               wr = sogm_merge({31'h0000_0000, s.run}, s.wdata, s.wstrb);
               next_s.run = wr[0];
            end
            sogm_pkg::ADDR_IRQ_MASK: begin
               wr = sogm_merge({28'h000_0000, s.irq_mask}, s.wdata, s.wstrb);
               next_s.irq_mask = wr[3:0];
            end
            sogm_pkg::ADDR_TEACH: begin
               wr = sogm_merge({16'h0000, s.teach}, s.wdata, s.wstrb);
               next_s.teach = wr[15:0];
            end
            sogm_pkg::ADDR_NAME: begin
               wr = sogm_merge({16'h0000, s.name}, s.wdata, s.wstrb);
               next_s.name = wr[15:0];
            end
            sogm_pkg::ADDR_STATUS, sogm_pkg::ADDR_IRQ_STAT, sogm_pkg::ADDR_SERIAL: wr = 32'h0000_0000;
            default: next_s.bresp = sogm_pkg::RESP_SLVERR;
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid; // reset leaves it low, so reads must reopen here
      next_s.irq = |(next_s.irq_st & next_s.irq_mask);
   end

   // state register; power-up clears the link so it rebuilds
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.run <= 1'b1;
         s.teach <= sogm_pkg::TEACH_RESET;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign pins_out = s.pout;
   assign leds = s.leds;
   assign irq = s.irq;
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rdata = s.rdata;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_out_follow: assert property ((s.ready && s.sync2[0] && s.pl == sogm_pkg::PL_NORMAL) |=>
      (pins_out.safety_out_one == $past(s.sync2[1]) && pins_out.safety_out_two == $past(s.sync2[2])))
      else $error("output does not follow its input channel");
   chk_absent_low: assert property (!s.sync2[0] |=> !pins_out.safety_out_one && !pins_out.safety_out_two)
      else $error("output high without actuator");
   chk_not_ready: assert property (!s.ready |=> !pins_out.safety_out_one && !pins_out.safety_out_two)
      else $error("output high before ready");
   chk_unequal_entry: assert property ((s.pl == sogm_pkg::PL_NORMAL && s.prev[1] && !s.sync2[1]
      && s.sync2[2]) |=> s.pl == sogm_pkg::PL_UNEQUAL) else $error("unequal state missed");
   chk_lock_entry: assert property ((s.pl == sogm_pkg::PL_UNEQUAL && !s.fell_two && !s.prev[1]
      && s.sync2[1] && s.sync2[2]) |=> s.pl == sogm_pkg::PL_LOCK) else $error("lock missed");
   chk_lock_hold: assert property ((s.pl == sogm_pkg::PL_LOCK && (s.sync2[1] || s.sync2[2]))
      |=> s.pl == sogm_pkg::PL_LOCK ##1 !pins_out.safety_out_one && !pins_out.safety_out_two)
      else $error("lock released or leaked");
   chk_status_plain: assert property (!s.attached |=> pins_out.status_diag_output == $past(s.sync2[0]))
      else $error("status output not presence");
   chk_diag_ignored: assert property (!s.attached |=> s.rx == sogm_pkg::RX_IDLE)
      else $error("diag input read while detached");
   chk_tx_bits: assert property ((s.attached && s.tx_busy) |=>
      pins_out.status_diag_output == $past(s.tx_sh[0])) else $error("transmit bit wrong");
   chk_powerup_link: assert property ($fell(rst) |-> !s.attached && !s.tx_busy)
      else $error("link not rebuilt at power-up");
   chk_serial_reply: assert property (($rose(s.tx_busy) && s.rx_sh == sogm_pkg::CMD_SERIAL)
      |-> s.tx_sh[16:1] == sogm_pkg::SERIAL_NUM) else $error("serial reply wrong");
   chk_name_reply: assert property (($rose(s.tx_busy) && s.rx_sh == sogm_pkg::CMD_NAME)
      |-> s.tx_sh[16:1] == $past(s.name)) else $error("name reply wrong");

   cov_unequal: cover property (s.pl == sogm_pkg::PL_UNEQUAL);
   cov_lock: cover property (s.pl == sogm_pkg::PL_LOCK ##1 s.pl == sogm_pkg::PL_NORMAL);
   cov_attach: cover property ($rose(s.attached));
   cov_reply: cover property ($fell(s.tx_busy));
endmodule

// file: verification/sogm_far_model.sv
/*
 far side model: upstream sensor chain levels, actuator presence and the
 diagnostics fieldbus module on the serial diagnostic pair.
 assumes the bench calls its tasks just after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module sogm_far_model (
   // clock
   input wire logic clk_sys,
   // pins towards the block
   output sogm_pkg::sogm_pins_in_s pins_in,
   // reply line from the block
   input wire logic status_line
);
   localparam int BIT_CYC = sogm_pkg::DIAG_BIT_CYC;

   // diagnostic line pulled up while the module stays quiet
   initial begin
      pins_in = '0;
      pins_in.diag_input = 1'b1;
   end

   // chain levels and actuator presence, changed just after an edge
   task automatic set_safety(input logic act, input logic in1, input logic in2);
      @(posedge clk_sys);
      pins_in.actuator_detect <= act;
      pins_in.safety_input_one <= in1;
      pins_in.safety_input_two <= in2;
   endtask

   // one bit time on the diagnostic line
   task automatic drive_bit(input logic b);
      pins_in.diag_input <= b;
      repeat (BIT_CYC) @(posedge clk_sys);
   endtask

   // one falling edge announces the module after every power-up
   task automatic attach();
      @(posedge clk_sys);
      drive_bit(1'b0);
      drive_bit(1'b1);
      drive_bit(1'b1);
   endtask

   // start bit, eight bits lsb first, stop bit
   task automatic send_frame(input logic [7:0] cmd);
      @(posedge clk_sys);
      drive_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
         drive_bit(cmd[i]);
      end
      drive_bit(1'b1);
   endtask

   // sample the reply mid-bit; bounded wait so a silent block cannot hang us
   task automatic get_reply(output logic [15:0] data, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      data = '0;
      while (status_line !== 1'b0 && n < 40000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n < 40000) begin
         repeat (BIT_CYC / 2) @(posedge clk_sys);
         for (int i = 0; i < 16; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            data[i] = status_line;
         end
         repeat (BIT_CYC) @(posedge clk_sys);
         ok = (status_line === 1'b1);
      end
   endtask

   // only one subscriber on this chain, well inside the module limit
   task automatic transact(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
      fork
         send_frame(cmd);
         get_reply(data, ok);
      join
   endtask
endmodule

// file: verification/safety_output_gating_monitor_tb.sv
/*
 bench of the safety output gating monitor: startup, a table of pin cases,
 then plausibility, registers, interrupt and diagnostics link tests.
 assumes the far model drives the pins and this bench is the bus master.
*/
`timescale 1ns/1ps
module safety_output_gating_monitor_tb;
   logic clk_sys, rst, irq;
   sogm_pkg::sogm_pins_in_s pins_in;
   sogm_pkg::sogm_pins_out_s pins_out;
   sogm_pkg::sogm_leds_s leds;
   logic [7:0] aw_addr, ar_addr;
   logic [31:0] w_data, r_data, rd;
   logic [3:0] w_strb;
   logic [1:0] b_resp, r_resp, rs;
   logic aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready, ar_valid, ar_ready, r_valid, r_ready;
   logic [15:0] reply;
   logic reply_ok;
   int err_count, checks, n;
   // {act, in1, in2, expected status, out2, out1}
   logic [5:0] rows [8] = '{6'h3f, 6'h18, 6'h24, 6'h35, 6'h24, 6'h2e, 6'h24, 6'h3f};

   sogm_far_model far (.clk_sys(clk_sys), .pins_in(pins_in), .status_line(pins_out.status_diag_output));
   sogm_top uut (.clk_sys(clk_sys), .rst(rst), .pins_in(pins_in), .pins_out(pins_out), .leds(leds), .irq(irq),
      .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
      .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
      .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
      .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
      .s_axi_rready(r_ready));

   // 250 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic stop_test();
      $display("counts: %0d mismatches of %0d checks", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // both halves offered together, each dropped at its own handshake edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      int k;
      logic aw_done, w_done;
      k = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      aw_addr <= a;
      w_data <= d;
      w_strb <= 4'hf;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      while (!(aw_done && w_done) && k < 200) begin
         @(posedge clk_sys);
         k++;
         if (aw_valid && aw_ready) begin
            aw_done = 1'b1;
            aw_valid <= 1'b0;
         end
         if (w_valid && w_ready) begin
            w_done = 1'b1;
            w_valid <= 1'b0;
         end
      end
      do begin
         @(posedge clk_sys);
         k++;
      end while (b_valid !== 1'b1 && k < 200);
      resp = b_resp;
      aw_valid <= 1'b0;
      w_valid <= 1'b0;
      b_ready <= 1'b0;
      chk("write answered", 32'h0000_0001, 32'(k < 200));
   endtask

   // rready held from the start; data taken at the rvalid edge
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int k;
      k = 0;
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
         if (ar_valid && ar_ready)
            ar_valid <= 1'b0;
      end while (r_valid !== 1'b1 && k < 200);
      d = r_data;
      resp = r_resp;
      ar_valid <= 1'b0;
      r_ready <= 1'b0;
      chk("read answered", 32'h0000_0001, 32'(k < 200));
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      axi_read(a, rd, rs);
      chk(what, exp, rd);
   endtask

   // watchdog: the link transfer dominates, about 58000 cycles
   initial begin
      repeat (95000) @(posedge clk_sys);
      err_count++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      {aw_addr, ar_addr, w_data, w_strb} = '0;
      {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
      err_count = 0;
      checks = 0;
      cyc(4);
      rst <= 1'b0;
      // startup: no mapping before ready
      far.set_safety(1'b1, 1'b1, 1'b1);
      cyc(20);
      chk("outputs before ready", 32'h0000_0000, 32'(pins_out[1:0]));
      chk("green before ready", 32'h0000_0000, 32'(leds.device_green));
      n = 0;
      while (leds.device_green !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
      end
      cyc(4);
      chk("outputs once ready", 32'h0000_0007, 32'(pins_out));
      chk("green once ready", 32'h0000_0001, 32'(leds.device_green));
      $display("test startup done");
      // ordinary cases from the table
      for (int i = 0; i < 8; i++) begin
         far.set_safety(rows[i][5], rows[i][4], rows[i][3]);
         cyc(6);
         chk("pins_out row", 32'(rows[i][2:0]), 32'(pins_out));
      end
      $display("test table done");
      // one channel falls, returns, then both low clear the lock
      far.set_safety(1'b1, 1'b0, 1'b1);
      cyc(6);
      chk("unequal outputs", 32'h0000_0006, 32'(pins_out));
      rd_chk(sogm_pkg::ADDR_STATUS, 32'h0000_01ed, "unequal status");
      far.set_safety(1'b1, 1'b1, 1'b1);
      cyc(6);
      chk("lock outputs", 32'h0000_0004, 32'(pins_out));
      chk("green in lock", 32'h0000_0000, 32'(leds.device_green));
      far.set_safety(1'b1, 1'b0, 1'b0);
      cyc(6);
      far.set_safety(1'b1, 1'b1, 1'b1);
      cyc(6);
      chk("outputs after both low", 32'h0000_0007, 32'(pins_out));
      $display("test plausibility done");
      // registers: reset value, read-only, unmapped
      rd_chk(sogm_pkg::ADDR_TEACH, 32'h0000_0020, "teach reset");
      axi_write(sogm_pkg::ADDR_TEACH, 32'h0000_0007, rs);
      rd_chk(sogm_pkg::ADDR_TEACH, 32'h0000_0007, "teach written");
      axi_write(sogm_pkg::ADDR_SERIAL, 32'hffff_ffff, rs);
      rd_chk(sogm_pkg::ADDR_SERIAL, 32'(sogm_pkg::SERIAL_NUM), "serial read only");
      axi_read(8'h1c, rd, rs);
      chk("unmapped rresp", 32'(sogm_pkg::RESP_SLVERR), 32'(rs));
      chk("unmapped rdata", 32'h0000_0000, rd);
      axi_write(8'h1c, 32'h0000_0001, rs);
      chk("unmapped bresp", 32'(sogm_pkg::RESP_SLVERR), 32'(rs));
      $display("test registers done");
      // interrupt raised, cleared by reading, then masked
      axi_write(sogm_pkg::ADDR_IRQ_MASK, 32'(1) << sogm_pkg::IRQ_ACT, rs);
      axi_read(sogm_pkg::ADDR_IRQ_STAT, rd, rs);
      far.set_safety(1'b0, 1'b1, 1'b1);
      cyc(6);
      chk("irq raised", 32'h0000_0001, 32'(irq));
      rd_chk(sogm_pkg::ADDR_IRQ_STAT, 32'(1) << sogm_pkg::IRQ_ACT, "irq status");
      cyc(2);
      chk("irq cleared", 32'h0000_0000, 32'(irq));
      axi_write(sogm_pkg::ADDR_IRQ_MASK, 32'h0000_0000, rs);
      far.set_safety(1'b1, 1'b1, 1'b1);
      cyc(6);
      chk("irq masked", 32'h0000_0000, 32'(irq));
      $display("test interrupt done");
      // diagnostics module attaches, then polls the serial number
      far.attach();
      far.set_safety(1'b0, 1'b1, 1'b1);
      cyc(6);
      chk("status idle when attached", 32'h0000_0001, 32'(pins_out.status_diag_output));
      far.transact(sogm_pkg::CMD_SERIAL, reply, reply_ok);
      chk("reply serial", 32'(sogm_pkg::SERIAL_NUM), 32'(reply));
      chk("reply framed", 32'h0000_0001, 32'(reply_ok));
      $display("test diagnostics done");
      stop_test();
   end
endmodule
